// *** dcp_pkg.sv ***
// Shared constants, types and reset image of the configuration port
package dcp_pkg;

    localparam int          NUM_REGS        = 64;
    localparam int          BYTES_PER_REG   = 4;
    localparam int          NUM_BYTES       = NUM_REGS * BYTES_PER_REG;
    localparam int          ADDR_W          = 8;
    localparam int          REG_ADDR_W      = 6;
    localparam int          LANE_W          = 2;
    localparam int          WORD_W          = 32;

    localparam int          INSTR_RW_BIT    = 7;
    localparam int          INSTR_ADDR_MSB  = 5;

    localparam logic [7:0]  CTRL_FUNC_ONE_ADDR = 8'h00;
    localparam int          LSB_FIRST_BIT      = 0;
    localparam int          SDIO_IN_ONLY_BIT   = 1;

    localparam logic [3:0]  FSEL_PARALLEL   = 4'h0;
    localparam logic [3:0]  FSEL_SERIAL     = 4'h1;

    typedef enum logic [0:0] {
        PH_INSTR = 1'b0,
        PH_DATA  = 1'b1
    } dcp_phase_e;

    // Reset value of each register byte, indexed by byte address
    function automatic logic [7:0] reset_byte(input logic [7:0] addr);
        logic [7:0] val;
        val = 8'h00;
        unique case (addr)
            8'h00:   val = 8'h08;
            8'h02:   val = 8'h01;
            8'h05:   val = 8'h09;
            8'h08:   val = 8'h1C;
            8'h0C:   val = 8'h20;
            8'h0D:   val = 8'h21;
            8'h0E:   val = 8'h05;
            default: val = 8'h00;
        endcase
        return val;
    endfunction : reset_byte

endpackage : dcp_pkg

// *** dcp_link_if.sv ***
// Signals between the core clock side and the serial clock engine
`timescale 1ns/1ns
interface dcp_link_if #(
    parameter int NUM_BYTES = dcp_pkg::NUM_BYTES
);
    logic                       wrToggle;
    logic [dcp_pkg::ADDR_W-1:0] wrAddr;
    logic [7:0]                 wrData;
    logic                       lsbFirst;
    logic                       inputOnly;
    logic                       serialMode;
    logic [NUM_BYTES*8-1:0]     image;

    modport eng  (output wrToggle, wrAddr, wrData,
                  input  lsbFirst, inputOnly, serialMode, image);
    modport core (input  wrToggle, wrAddr, wrData,
                  output lsbFirst, inputOnly, serialMode, image);
endinterface : dcp_link_if

// *** dcp_reg_store.sv ***
// Register buffer and active register image with commit
`timescale 1ns/1ns
module dcp_reg_store #(
    parameter int NUM_BYTES = dcp_pkg::NUM_BYTES
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_b,
    input  wire logic                       wrEn,
    input  wire logic [dcp_pkg::ADDR_W-1:0] wrAddr,
    input  wire logic [7:0]                 wrData,
    input  wire logic                       commit,
    output logic      [NUM_BYTES*8-1:0]     image
);

    genvar i;
    generate
        for (i = 0; i < NUM_BYTES; i++) begin : g_byte
            localparam logic [7:0] RST = dcp_pkg::reset_byte(8'(i));
            logic [7:0] buf_ff;
            logic [7:0] act_ff;
            logic [7:0] nxt_buf;
            logic [7:0] nxt_act;

            always_comb begin
                nxt_buf = buf_ff;
                if (wrEn && (wrAddr == 8'(i))) begin
                    nxt_buf = wrData;
                end
                // A write in the commit cycle is carried into the active copy
                nxt_act = commit ? nxt_buf : act_ff;
            end

            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    buf_ff <= RST;
                    act_ff <= RST;
                end else begin
                    buf_ff <= nxt_buf;
                    act_ff <= nxt_act;
                end
            end

            assign image[i*8 +: 8] = act_ff;
        end
    endgenerate

endmodule : dcp_reg_store

// *** dcp_serial_engine.sv ***
// Serial port engine running on the serial clock
`timescale 1ns/1ns
module dcp_serial_engine (
    input  wire logic   sclk,
    input  wire logic   rst_b,
    input  wire logic   portResync,
    input  wire logic   chipSelect_b,
    input  wire logic   sdioIn,
    output logic        sdioOut,
    output logic        sdioOe,
    output logic        serialDataOut,
    output logic        serialDataOutOe,
    dcp_link_if.eng     link
);

    typedef logic [dcp_pkg::LANE_W-1:0] dcp_lane_t;

    logic                               engRst_b;
    logic                               outRst_b;
    logic [2:0]                         cfgMeta_ff;
    logic [2:0]                         cfg_ff;
    logic                               lsbFirst;
    logic                               inputOnly;
    logic                               serMode;
    dcp_pkg::dcp_phase_e                phase_ff;
    dcp_pkg::dcp_phase_e                nxt_phase;
    logic [2:0]                         bitCnt_ff;
    logic [2:0]                         nxt_bitCnt;
    logic [dcp_pkg::LANE_W-1:0]         byteCnt_ff;
    logic [dcp_pkg::LANE_W-1:0]         nxt_byteCnt;
    logic [7:0]                         shift_ff;
    logic [7:0]                         nxt_shift;
    logic [7:0]                         inBits;
    logic [7:0]                         rawBits;
    logic [7:0]                         revBits;
    logic                               isRead_ff;
    logic                               nxt_isRead;
    logic [dcp_pkg::REG_ADDR_W-1:0]     regAddr_ff;
    logic [dcp_pkg::REG_ADDR_W-1:0]     nxt_regAddr;
    logic                               wrTgl_ff;
    logic                               nxt_wrTgl;
    logic [dcp_pkg::ADDR_W-1:0]         wrAddr_ff;
    logic [dcp_pkg::ADDR_W-1:0]         nxt_wrAddr;
    logic [7:0]                         wrData_ff;
    logic [7:0]                         nxt_wrData;
    logic [dcp_pkg::LANE_W-1:0]         lane;
    logic [4:0]                         pos;
    logic [dcp_pkg::WORD_W-1:0]         word;
    logic                               driveNow;
    logic                               outBit;

    assign engRst_b  = rst_b & ~portResync;
    assign outRst_b  = engRst_b & ~chipSelect_b;
    assign lsbFirst  = cfg_ff[0];
    assign inputOnly = cfg_ff[1];
    assign serMode   = cfg_ff[2];
    assign rawBits   = {shift_ff[6:0], sdioIn};

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_rev
            assign revBits[i] = rawBits[7-i];
        end
    endgenerate

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            cfgMeta_ff <= 3'h0;
            cfg_ff     <= 3'h0;
        end else begin
            cfgMeta_ff <= {link.serialMode, link.inputOnly, link.lsbFirst};
            cfg_ff     <= cfgMeta_ff;
        end
    end

    always_comb begin
        // Config settles only two rises into a frame, so bit order is applied per whole byte
        inBits      = lsbFirst ? revBits : rawBits;
        lane        = lsbFirst ? byteCnt_ff : ~byteCnt_ff;
        nxt_phase   = phase_ff;
        nxt_bitCnt  = bitCnt_ff;
        nxt_byteCnt = byteCnt_ff;
        nxt_shift   = shift_ff;
        nxt_isRead  = isRead_ff;
        nxt_regAddr = regAddr_ff;
        nxt_wrTgl   = wrTgl_ff;
        nxt_wrAddr  = wrAddr_ff;
        nxt_wrData  = wrData_ff;
        // Chip select high freezes every counter in place
        if (!chipSelect_b) begin
            nxt_shift  = rawBits;
            nxt_bitCnt = 3'(bitCnt_ff + 3'h1);
            if (bitCnt_ff == 3'h7) begin
                unique case (phase_ff)
                    dcp_pkg::PH_INSTR: begin
                        nxt_isRead  = inBits[dcp_pkg::INSTR_RW_BIT];
                        nxt_regAddr = inBits[dcp_pkg::INSTR_ADDR_MSB:0];
                        nxt_byteCnt = '0;
                        nxt_phase   = dcp_pkg::PH_DATA;
                    end
                    dcp_pkg::PH_DATA: begin
                        if (!isRead_ff) begin
                            nxt_wrTgl  = ~wrTgl_ff;
                            nxt_wrAddr = {regAddr_ff, lane};
                            nxt_wrData = inBits;
                        end
                        nxt_byteCnt = dcp_lane_t'(byteCnt_ff + 1'b1);
                        if (byteCnt_ff == {dcp_pkg::LANE_W{1'b1}}) begin
                            nxt_phase = dcp_pkg::PH_INSTR;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sclk or negedge engRst_b) begin
        if (!engRst_b) begin
            phase_ff   <= dcp_pkg::PH_INSTR;
            bitCnt_ff  <= 3'h0;
            byteCnt_ff <= '0;
            shift_ff   <= 8'h00;
            isRead_ff  <= 1'b0;
            regAddr_ff <= '0;
        end else begin
            phase_ff   <= nxt_phase;
            bitCnt_ff  <= nxt_bitCnt;
            byteCnt_ff <= nxt_byteCnt;
            shift_ff   <= nxt_shift;
            isRead_ff  <= nxt_isRead;
            regAddr_ff <= nxt_regAddr;
        end
    end

    // Write handoff survives a resync so completed bytes are kept
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            wrTgl_ff  <= 1'b0;
            wrAddr_ff <= '0;
            wrData_ff <= 8'h00;
        end else begin
            wrTgl_ff  <= nxt_wrTgl;
            wrAddr_ff <= nxt_wrAddr;
            wrData_ff <= nxt_wrData;
        end
    end

    assign link.wrToggle = wrTgl_ff;
    assign link.wrAddr   = wrAddr_ff;
    assign link.wrData   = wrData_ff;

    always_comb begin
        pos      = {byteCnt_ff, bitCnt_ff};
        word     = link.image[{regAddr_ff, 5'h00} +: dcp_pkg::WORD_W];
        outBit   = lsbFirst ? word[pos] : word[~pos];
        driveNow = (phase_ff == dcp_pkg::PH_DATA) && isRead_ff && serMode;
    end

    always_ff @(negedge sclk or negedge outRst_b) begin
        if (!outRst_b) begin
            sdioOut         <= 1'b0;
            sdioOe          <= 1'b0;
            serialDataOut   <= 1'b0;
            serialDataOutOe <= 1'b0;
        end else begin
            sdioOut         <= outBit;
            sdioOe          <= driveNow & ~inputOnly;
            serialDataOut   <= outBit;
            serialDataOutOe <= driveNow & inputOnly;
        end
    end

endmodule : dcp_serial_engine

// *** dcp_config_port.sv ***
// Top of the configuration port: pin sync, parallel port, update and store
`timescale 1ns/1ns
module dcp_config_port #(
    parameter int NUM_BYTES = dcp_pkg::NUM_BYTES
) (
    input  wire logic           mclk,
    input  wire logic           rst_b,
    input  wire logic           sclk,
    input  wire logic           chipSelect_b,
    input  wire logic           sdioIn,
    output logic                sdioOut,
    output logic                sdioOe,
    output logic                serialDataOut,
    output logic                serialDataOutOe,
    input  wire logic           portResync,
    input  wire logic [3:0]     functionSelect,
    input  wire logic           updateStrobe,
    input  wire logic           widthSelect,
    input  wire logic [7:0]     parAddr,
    input  wire logic [15:0]    parDataIn,
    output logic      [15:0]    parDataOut,
    output logic      [1:0]     parDataOe,
    input  wire logic           parWrite_b,
    input  wire logic           parRead_b,
    output logic                serialMode,
    output logic                parallelMode
);

    localparam int          PIN_W   = 32;
    // Write and read strobes idle high so their synchronisers start high; the update strobe starts low
    localparam logic [31:0] PIN_RST = 32'h0600_0000;

    logic [PIN_W-1:0]           pinRaw;
    logic [PIN_W-1:0]           pinMeta_ff;
    logic [PIN_W-1:0]           pin_ff;
    logic [3:0]                 fselS;
    logic                       updS;
    logic                       wrBS;
    logic                       rdBS;
    logic                       w16S;
    logic [7:0]                 addrS;
    logic [15:0]                dataS;

    logic                       updPrev_ff;
    logic                       wrPrev_ff;
    logic                       tglMeta_ff;
    logic                       tglSync_ff;
    logic                       tglPrev_ff;
    logic                       commit;
    logic                       parWrFall;
    logic                       serWrEvent;

    logic                       pend_ff;
    logic                       nxt_pend;
    logic [7:0]                 pendAddr_ff;
    logic [7:0]                 nxt_pendAddr;
    logic [7:0]                 pendData_ff;
    logic [7:0]                 nxt_pendData;
    logic                       memWrEn;
    logic [7:0]                 memWrAddr;
    logic [7:0]                 memWrData;

    logic                       nxt_serialMode;
    logic                       nxt_parallelMode;
    logic [15:0]                nxt_parDataOut;
    logic [1:0]                 nxt_parDataOe;
    logic [7:0]                 lowAddr;
    logic [NUM_BYTES*8-1:0]     image;

    dcp_link_if #(.NUM_BYTES(NUM_BYTES)) link ();

    // Every pin reaching the core clock passes two flip-flops
    assign pinRaw = {functionSelect, updateStrobe, parWrite_b, parRead_b, widthSelect,
                     parAddr, parDataIn};

    genvar i;
    generate
        for (i = 0; i < PIN_W; i++) begin : g_sync
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    pinMeta_ff[i] <= PIN_RST[i];
                    pin_ff[i]     <= PIN_RST[i];
                end else begin
                    pinMeta_ff[i] <= pinRaw[i];
                    pin_ff[i]     <= pinMeta_ff[i];
                end
            end
        end
    endgenerate

    assign fselS = pin_ff[31:28];
    assign updS  = pin_ff[27];
    assign wrBS  = pin_ff[26];
    assign rdBS  = pin_ff[25];
    assign w16S  = pin_ff[24];
    assign addrS = pin_ff[23:16];
    assign dataS = pin_ff[15:0];

    // Serial write toggle crosses in from the serial clock
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tglMeta_ff <= 1'b0;
            tglSync_ff <= 1'b0;
        end else begin
            tglMeta_ff <= link.wrToggle;
            tglSync_ff <= tglMeta_ff;
        end
    end

    assign commit     = updS & ~updPrev_ff;
    assign parWrFall  = wrPrev_ff & ~wrBS & parallelMode;
    assign serWrEvent = (tglSync_ff ^ tglPrev_ff) & serialMode;
    assign lowAddr    = 8'(addrS - 8'h01);

    always_comb begin
        nxt_serialMode   = (fselS == dcp_pkg::FSEL_SERIAL);
        nxt_parallelMode = (fselS == dcp_pkg::FSEL_PARALLEL);
        nxt_pend         = 1'b0;
        nxt_pendAddr     = pendAddr_ff;
        nxt_pendData     = pendData_ff;
        memWrEn          = 1'b0;
        memWrAddr        = 8'h00;
        memWrData        = 8'h00;
        if (pend_ff) begin
            memWrEn   = 1'b1;
            memWrAddr = pendAddr_ff;
            memWrData = pendData_ff;
        end else if (parWrFall) begin
            memWrEn   = 1'b1;
            memWrAddr = addrS;
            if (w16S) begin
                memWrData    = dataS[15:8];
                nxt_pend     = 1'b1;
                nxt_pendAddr = lowAddr;
                nxt_pendData = dataS[7:0];
            end else begin
                memWrData = dataS[7:0];
            end
        end else if (serWrEvent) begin
            memWrEn   = 1'b1;
            memWrAddr = link.wrAddr;
            memWrData = link.wrData;
        end
    end

    // Parallel readback of the active registers while read strobe is low
    always_comb begin
        nxt_parDataOe  = 2'h0;
        nxt_parDataOut = 16'h0000;
        if (parallelMode && !rdBS) begin
            if (w16S) begin
                nxt_parDataOe  = 2'h3;
                nxt_parDataOut = {image[addrS*8 +: 8], image[lowAddr*8 +: 8]};
            end else begin
                nxt_parDataOe  = 2'h1;
                nxt_parDataOut = {8'h00, image[addrS*8 +: 8]};
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            updPrev_ff   <= 1'b0;
            wrPrev_ff    <= 1'b1;
            tglPrev_ff   <= 1'b0;
            pend_ff      <= 1'b0;
            pendAddr_ff  <= 8'h00;
            pendData_ff  <= 8'h00;
            serialMode   <= 1'b0;
            parallelMode <= 1'b0;
            parDataOut   <= 16'h0000;
            parDataOe    <= 2'h0;
        end else begin
            updPrev_ff   <= updS;
            wrPrev_ff    <= wrBS;
            tglPrev_ff   <= tglSync_ff;
            pend_ff      <= nxt_pend;
            pendAddr_ff  <= nxt_pendAddr;
            pendData_ff  <= nxt_pendData;
            serialMode   <= nxt_serialMode;
            parallelMode <= nxt_parallelMode;
            parDataOut   <= nxt_parDataOut;
            parDataOe    <= nxt_parDataOe;
        end
    end

    dcp_reg_store #(.NUM_BYTES(NUM_BYTES)) u_store (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .wrEn   (memWrEn),
        .wrAddr (memWrAddr),
        .wrData (memWrData),
        .commit (commit),
        .image  (image)
    );

    // Active-register levels are static between updates; serialMode follows functionSelect
    assign link.image      = image;
    assign link.lsbFirst   = image[dcp_pkg::CTRL_FUNC_ONE_ADDR*8 + dcp_pkg::LSB_FIRST_BIT];
    assign link.inputOnly  = image[dcp_pkg::CTRL_FUNC_ONE_ADDR*8 + dcp_pkg::SDIO_IN_ONLY_BIT];
    assign link.serialMode = serialMode;

    dcp_serial_engine u_serial (
        .sclk            (sclk),
        .rst_b           (rst_b),
        .portResync      (portResync),
        .chipSelect_b    (chipSelect_b),
        .sdioIn          (sdioIn),
        .sdioOut         (sdioOut),
        .sdioOe          (sdioOe),
        .serialDataOut   (serialDataOut),
        .serialDataOutOe (serialDataOutOe),
        .link            (link)
    );

endmodule : dcp_config_port

// *** dcp_config_port_checker.sv ***
// Pin-level assertions for the configuration port
`timescale 1ns/1ns
module dcp_config_port_checker (
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       portResync,
    input wire logic       chipSelect_b,
    input wire logic       sdioOe,
    input wire logic       serialDataOutOe,
    input wire logic [3:0] functionSelect,
    input wire logic       parRead_b,
    input wire logic [1:0] parDataOe,
    input wire logic       serialMode,
    input wire logic       parallelMode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_cs_release: assert property (
        chipSelect_b |-> !sdioOe && !serialDataOutOe) else $error("driven while deselected");
    a_oe_exclusive: assert property (
        !(sdioOe && serialDataOutOe)) else $error("both serial outputs driven");
    a_serial_select: assert property (
        (functionSelect == dcp_pkg::FSEL_SERIAL)[*4] |-> serialMode && !parallelMode)
        else $error("serial mode not selected");
    a_par_select: assert property (
        (functionSelect == dcp_pkg::FSEL_PARALLEL)[*4] |-> parallelMode && !serialMode)
        else $error("parallel mode not selected");
    a_read_release: assert property (
        parRead_b[*5] |-> parDataOe == 2'h0) else $error("parallel data driven when idle");
    a_read_drive: assert property (
        $rose(parDataOe[0]) |-> !$past(parRead_b, 2)) else $error("parallel drive unasked");
    a_par_off: assert property (
        (!parallelMode)[*4] |-> parDataOe == 2'h0) else $error("parallel drive in serial mode");
    a_resync_quiet: assert property (
        portResync[*2] |-> !sdioOe && !serialDataOutOe) else $error("driven during resync");
    c_two_wire: cover property (sdioOe);
    c_three_wire: cover property (serialDataOutOe);
    c_wide_read: cover property (parDataOe == 2'h3);
endmodule : dcp_config_port_checker

bind dcp_config_port dcp_config_port_checker chk_u (.*);

// *** dcp_host_model.sv ***
// Behavioural serial host driving frames into the port
`timescale 1ns/1ns
module dcp_host_model (
    output logic     sclk,
    output logic     chipSelect_b,
    output logic     hostData,
    output logic     hostOe,
    input wire logic sdioLine,
    input wire logic serialDataOut
);
    // Set by a scenario to keep chip select low between frames
    logic holdSel = 1'b0;
    initial begin
        sclk = 1'b0;
        chipSelect_b = 1'b1;
        hostData = 1'b0;
        hostOe = 1'b1;
    end
    // Instruction then 32-bit word; nBits below 40 cuts the frame short
    task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, input logic lsb,
                        input logic serial_data_out, input int pauseAt, input int nBits,
                        output logic [31:0] rd);
        logic [39:0] bits;
        rd = 32'h0;
        bits = {ins, wd};
        chipSelect_b = 1'b0;
        for (int k = 0; k < nBits; k++) begin
            if (k == pauseAt) begin
                chipSelect_b = 1'b1;
                #200 chipSelect_b = 1'b0;
            end
            if (k == 8 && pauseAt < 0) #150;
            hostOe = !(ins[7] && k >= 8);
            hostData = lsb ? bits[k < 8 ? 32 + k : k - 8] : bits[39 - k];
            #32 sclk = 1'b1;
            if (k >= 8) rd[lsb ? k - 8 : 39 - k] = serial_data_out ? serialDataOut : sdioLine;
            #32 sclk = 1'b0;
        end
        hostOe = 1'b1;
        #64 chipSelect_b = !holdSel;
        #64;
    endtask : xfer
endmodule : dcp_host_model

// *** dcp_config_port_tb.sv ***
// Self-checking bench for the configuration port
`timescale 1ns/1ns
module dcp_config_port_tb;
    logic        mclk = 1'b0, rst_b = 1'b0, floatBit = 1'b0;
    logic        sclk, chipSelect_b, hostData, hostOe, sdioIn, sdioOut, sdioOe;
    logic        serialDataOut, serialDataOutOe, serialMode, parallelMode;
    logic        portResync = 1'b0, updateStrobe = 1'b0, widthSelect = 1'b0;
    logic        parWrite_b = 1'b1, parRead_b = 1'b1;
    logic [3:0]  functionSelect = 4'h1;
    logic [7:0]  parAddr = 8'h00;
    logic [15:0] parDataIn = 16'h0000, parDataOut;
    logic [1:0]  parDataOe;
    logic [31:0] rdv;
    int          miscompares = 0, numChecks = 0;
    always #5 mclk = ~mclk;
    always @(posedge mclk) floatBit <= ~floatBit;
    // Released shared pin shows a changing pattern
    assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostData : floatBit);
    dcp_config_port dut_u (.*);
    dcp_host_model host_u (.sdioLine(sdioIn), .*);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic upd;
        cyc(1);
        updateStrobe = 1'b1;
        cyc(3);
        updateStrobe = 1'b0;
        cyc(3);
    endtask : upd
    task automatic t_reset;
        host_u.xfer(8'h80, 32'h0, 1'b0, 1'b0, -1, 40, rdv);
        chk("reg0 reset", 32'h00010008, rdv);
        host_u.xfer(8'hC1, 32'h0, 1'b0, 1'b0, -1, 40, rdv);
        chk("reg1 reset", 32'h00000900, rdv);
        chk("serial mode", 32'h1, {31'h0, serialMode});
        $display("test reset done");
    endtask : t_reset
    task automatic t_write;
        host_u.holdSel = 1'b1;
        host_u.xfer(8'h45, 32'hA1B2C3D4, 1'b0, 1'b0, 12, 40, rdv);
        host_u.xfer(8'h85, 32'h0, 1'b0, 1'b0, -1, 40, rdv);
        host_u.holdSel = 1'b0;
        chk("reg5 before update", 32'h0, rdv);
        upd;
        host_u.xfer(8'h85, 32'h0, 1'b0, 1'b0, 3, 40, rdv);
        chk("reg5 after update", 32'hA1B2C3D4, rdv);
        $display("test write done");
    endtask : t_write
    task automatic t_format;
        host_u.xfer(8'h00, 32'h00010009, 1'b0, 1'b0, -1, 40, rdv);
        upd;
        host_u.xfer(8'h06, 32'h12345678, 1'b1, 1'b0, -1, 40, rdv);
        upd;
        host_u.xfer(8'h86, 32'h0, 1'b1, 1'b0, -1, 40, rdv);
        chk("reg6 lsb first", 32'h12345678, rdv);
        host_u.xfer(8'h00, 32'h0001000A, 1'b1, 1'b0, -1, 40, rdv);
        upd;
        host_u.xfer(8'h86, 32'h0, 1'b0, 1'b1, -1, 40, rdv);
        chk("reg6 three wire", 32'h12345678, rdv);
        host_u.xfer(8'h00, 32'h00010008, 1'b0, 1'b1, -1, 40, rdv);
        upd;
        host_u.xfer(8'h80, 32'h0, 1'b0, 1'b0, -1, 40, rdv);
        chk("reg0 restored", 32'h00010008, rdv);
        $display("test format done");
    endtask : t_format
    task automatic t_resync;
        host_u.xfer(8'h07, 32'hDEADBEEF, 1'b0, 1'b0, -1, 20, rdv);
        cyc(2);
        portResync = 1'b1;
        cyc(3);
        portResync = 1'b0;
        cyc(2);
        host_u.xfer(8'h85, 32'h0, 1'b0, 1'b0, -1, 40, rdv);
        chk("reg5 after resync", 32'hA1B2C3D4, rdv);
        $display("test resync done");
    endtask : t_resync
    task automatic pwr(input logic [7:0] a, input logic [15:0] d, input logic w);
        parAddr = a;
        parDataIn = d;
        widthSelect = w;
        cyc(4);
        parWrite_b = 1'b0;
        cyc(4);
        parWrite_b = 1'b1;
        cyc(4);
    endtask : pwr
    task automatic prd(input logic [7:0] a, input logic w);
        parAddr = a;
        widthSelect = w;
        cyc(4);
        parRead_b = 1'b0;
        cyc(6);
        rdv = {14'h0, parDataOe, parDataOut};
        parRead_b = 1'b1;
        cyc(6);
    endtask : prd
    task automatic t_parallel;
        functionSelect = 4'h0;
        cyc(6);
        chk("parallel mode", 32'h1, {31'h0, parallelMode});
        pwr(8'h20, 16'h003C, 1'b0);
        pwr(8'h23, 16'hA55A, 1'b1);
        upd;
        prd(8'h20, 1'b0);
        chk("par 8 bit", 32'h13C, {22'h0, rdv[17:16], rdv[7:0]});
        prd(8'h23, 1'b1);
        chk("par 16 bit", 32'h3A55A, rdv);
        $display("test parallel done");
    endtask : t_parallel
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        cyc(10);
        rst_b = 1'b1;
        cyc(8);
        t_reset;
        t_write;
        t_format;
        t_resync;
        t_parallel;
        tally_and_finish;
    end
    initial begin
        #200000;
        miscompares++;
        tally_and_finish;
    end
endmodule : dcp_config_port_tb
